// ==== verilog/crf_redundancy.sv ====
// controller redundancy election and supervision state machine
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"
module crf_redundancy
   import crf_pkg::*;
#(
   parameter int TICK_CYCLES = `CRF_TICK_CYCLES,
   parameter logic [63:0] LOCAL_NAME = 64'h0123456789abcdef // arbitrary
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [3:0] reg_addr, // register address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic sets_configured, // controller and forwarder sets configured
   input wire logic fabric_ready, // fabric configuration complete
   input wire logic link_set_up, // inter-controller link set non-empty
   input wire logic peer_fwd_reach, // peer reachable over a forwarder link
   input wire logic hello_rx, // peer hello received, one-cycle pulse
   input wire crf_xchg_type xchg_rsp, // priority exchange result
   input wire logic prio_req_rx, // peer priority exchange request received
   input wire logic [7:0] prio_req_val, // priority in that request
   input wire logic id_granted, // virtual identifier granted
   input wire logic step_done, // current fetch step finished
   input wire logic sync_rx, // sync_achieved_msg received from secondary
   input wire logic primary_req_rx, // link or zoning request from primary
   output crf_cmd_type cmd, // action pulses
   output logic req_accept, // primary request processed
   output logic [7:0] prio_out, // current advertised priority
   output logic is_primary, // acting as primary
   output logic is_secondary // acting as secondary
);
   // ====================================================
   // register file
   logic enable_ff;
   logic handover_ff;
   logic error_ff;
   logic [15:0] hello_ms_ff;
   logic [7:0] cfg_prio_ff;
   logic [7:0] prio_ff;
   logic [7:0] peer_prio_ff;
   crf_state_type state_ff, nxt_state;
   logic expired_ff;
   logic set_error;
   logic [31:0] nxt_rdata;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enable_ff <= 1'b0;
         hello_ms_ff <= `CRF_HELLO_MS_RST;
         cfg_prio_ff <= `CRF_PRIO_DEFAULT;
      end else if (set_error) begin
         enable_ff <= 1'b0;
      end else if (reg_wr && reg_addr == `CRF_ADDR_CTRL) begin
         enable_ff <= reg_wdata[`CRF_CTRL_EN_BIT];
      end else if (reg_wr && reg_addr == `CRF_ADDR_HELLO && reg_wdata[15:0] != 16'h0000) begin
         hello_ms_ff <= reg_wdata[15:0];
      end else if (reg_wr && reg_addr == `CRF_ADDR_PRIO && reg_wdata[7:0] != `CRF_PRIO_RSVD) begin
         cfg_prio_ff <= reg_wdata[7:0];
      end
   end

   // handover request lives only while primary operational
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         handover_ff <= 1'b0;
      end else if (reg_wr && reg_addr == `CRF_ADDR_CTRL && reg_wdata[`CRF_CTRL_HANDOVER_BIT]) begin
         handover_ff <= 1'b1;
      end else if (state_ff != ST_P_OPER) begin
         handover_ff <= 1'b0;
      end
   end

   // error flag: set wins over clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         error_ff <= 1'b0;
      end else if (set_error) begin
         error_ff <= 1'b1;
      end else if (reg_wr && reg_addr == `CRF_ADDR_CTRL && reg_wdata[`CRF_CTRL_ERRCLR_BIT]) begin
         error_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (reg_addr)
         `CRF_ADDR_CTRL: nxt_rdata = {30'h0, handover_ff, enable_ff};
         `CRF_ADDR_HELLO: nxt_rdata = {16'h0, hello_ms_ff};
         `CRF_ADDR_PRIO: nxt_rdata = {24'h0, cfg_prio_ff};
         `CRF_ADDR_STATUS: nxt_rdata = {16'h0, prio_ff, 1'b0, expired_ff, error_ff, 1'b0, 4'(state_ff)};
         `CRF_ADDR_PEER: nxt_rdata = {24'h0, peer_prio_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ====================================================
   // millisecond tick and timers
   logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_ff;
   logic tick;
   logic [15:0] hello_cnt_ff;
   logic [17:0] down_ms;
   logic [17:0] down_cnt_ff;
   logic peer_present;
   logic timers_on;

   // a divider below two cycles cannot make a one-cycle tick
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   assign tick = (tick_cnt_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tick_cnt_ff <= '0;
      end else if (tick) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 1'b1;
      end
   end

   // 2.5 x period, computed from the configured period
   assign down_ms = {1'b0, hello_ms_ff, 1'b0} + {3'b000, hello_ms_ff[15:1]};
   assign peer_present = link_set_up || peer_fwd_reach;
   assign timers_on = state_ff inside {ST_P_OPER, ST_P_XCHG, ST_S_INIT, ST_S_TOPO, ST_S_ALLOC,
                                       ST_S_NAME, ST_S_SYNC, ST_S_OPER};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hello_cnt_ff <= 16'h0000;
      end else if (!timers_on || !peer_present) begin
         hello_cnt_ff <= 16'h0000;
      end else if (tick) begin
         hello_cnt_ff <= (hello_cnt_ff + 16'h0001 >= hello_ms_ff) ? 16'h0000 : hello_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         down_cnt_ff <= 18'h00000;
         expired_ff <= 1'b0;
      end else if (!timers_on || hello_rx) begin
         down_cnt_ff <= down_ms;
         expired_ff <= 1'b0;
      end else if (tick && !expired_ff) begin
         if (down_cnt_ff <= 18'h00001) begin
            down_cnt_ff <= 18'h00000;
            expired_ff <= 1'b1;
         end else begin
            down_cnt_ff <= down_cnt_ff - 18'h00001;
         end
      end
   end

   // expiry as a one-cycle event, so the sole-primary announce fires once
   logic expire_evt;
   assign expire_evt = tick && !expired_ff && timers_on && !hello_rx && down_cnt_ff <= 18'h00001;

   // ====================================================
   // election state machine
   logic from_primary;
   logic link_up_d_ff;
   logic elect_primary;
   logic both_forced;

   // delayed copy finds the empty to non-empty change of the link set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         link_up_d_ff <= 1'b0;
      end else begin
         link_up_d_ff <= link_set_up;
      end
   end

   assign both_forced = prio_ff == `CRF_PRIO_FORCE && xchg_rsp.prio == `CRF_PRIO_FORCE;
   assign elect_primary = (prio_ff < xchg_rsp.prio) ||
                          (prio_ff == xchg_rsp.prio && LOCAL_NAME < xchg_rsp.name);
   assign set_error = state_ff == ST_XCHG && xchg_rsp.xchg_done && both_forced;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_INIT: if (sets_configured && fabric_ready) nxt_state = ST_ELECT;
         ST_ELECT: nxt_state = link_set_up ? ST_XCHG : ST_P_INIT;
         ST_XCHG: begin
            if (xchg_rsp.xchg_done) begin
               if (both_forced) nxt_state = ST_INIT;
               else if (elect_primary) nxt_state = ST_P_INIT;
               else nxt_state = ST_S_INIT;
            end
         end
         ST_P_INIT: if (id_granted) nxt_state = ST_P_OPER;
         ST_P_OPER: begin
            if (handover_ff) nxt_state = ST_S_OPER;
            else if (link_set_up && !link_up_d_ff) nxt_state = ST_P_XCHG;
         end
         ST_P_XCHG: begin
            if (xchg_rsp.xchg_done) begin
               nxt_state = (xchg_rsp.conflict || elect_primary) ? ST_P_OPER : ST_S_OPER;
            end
         end
         ST_S_INIT: if (link_set_up) nxt_state = ST_S_TOPO;
         ST_S_TOPO: if (step_done) nxt_state = ST_S_ALLOC;
         ST_S_ALLOC: if (step_done) nxt_state = ST_S_NAME;
         ST_S_NAME: if (step_done) nxt_state = ST_S_SYNC;
         ST_S_SYNC: nxt_state = ST_S_OPER;
         ST_S_OPER: begin
            if (expire_evt || (prio_req_rx && prio_req_val == `CRF_PRIO_REFUSE)) nxt_state = ST_P_OPER;
            else if (!link_set_up && !expired_ff) nxt_state = ST_S_INIT;
         end
         default: nxt_state = ST_INIT;
      endcase
      if (!enable_ff) nxt_state = ST_INIT;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= ST_INIT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // own priority
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prio_ff <= `CRF_PRIO_DEFAULT;
      end else if (state_ff == ST_INIT) begin
         prio_ff <= cfg_prio_ff;
      end else if (nxt_state == ST_P_INIT || (nxt_state == ST_P_OPER && state_ff != ST_P_OPER)) begin
         prio_ff <= `CRF_PRIO_PRIMARY;
      end else if (state_ff == ST_P_OPER && handover_ff) begin
         prio_ff <= `CRF_PRIO_REFUSE;
      end else if (nxt_state == ST_S_OPER && state_ff != ST_S_OPER) begin
         prio_ff <= cfg_prio_ff;
      end
   end

   // last priority the peer showed, kept for software
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         peer_prio_ff <= 8'h00;
      end else if (state_ff == ST_INIT) begin
         peer_prio_ff <= 8'h00;
      end else if (xchg_rsp.xchg_done) begin
         peer_prio_ff <= xchg_rsp.prio;
      end else if (prio_req_rx) begin
         peer_prio_ff <= prio_req_val;
      end
   end

   // ====================================================
   // action pulses
   logic enter_p;
   logic enter_s;
   assign enter_p = nxt_state == ST_P_OPER && state_ff != ST_P_OPER && state_ff != ST_P_XCHG;
   assign enter_s = nxt_state == ST_S_OPER && state_ff != ST_S_OPER;
   assign from_primary = state_ff == ST_P_OPER;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd <= '0;
      end else begin
         cmd <= '0;
         cmd.prio_xchg <= (nxt_state == ST_XCHG && state_ff == ST_ELECT) || enter_p || enter_s ||
                          (nxt_state == ST_P_XCHG && from_primary);
         cmd.announce_primary <= enter_p || (from_primary && (sync_rx || expire_evt));
         cmd.announce_peer <= from_primary && sync_rx;
         cmd.link_bringup <= enter_p || enter_s;
         cmd.id_request <= nxt_state == ST_P_INIT && state_ff != ST_P_INIT;
         cmd.get_topology_msg <= nxt_state == ST_S_TOPO && state_ff != ST_S_TOPO;
         cmd.get_id_alloc_msg <= nxt_state == ST_S_ALLOC && state_ff != ST_S_ALLOC;
         cmd.get_name_data <= nxt_state == ST_S_NAME && state_ff != ST_S_NAME;
         cmd.sync_achieved_msg <= nxt_state == ST_S_SYNC;
         cmd.hello <= timers_on && peer_present && tick && hello_cnt_ff == 16'h0000;
         cmd.isolate_link <= state_ff == ST_P_XCHG && xchg_rsp.xchg_done && xchg_rsp.conflict;
      end
   end

   // link and zoning requests are served only while synchronising
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_accept <= 1'b0;
      end else begin
         req_accept <= primary_req_rx && link_set_up &&
                       state_ff inside {ST_S_INIT, ST_S_TOPO, ST_S_ALLOC, ST_S_NAME, ST_S_SYNC};
      end
   end

   // role levels lag the state by one cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prio_out <= `CRF_PRIO_DEFAULT;
         is_primary <= 1'b0;
         is_secondary <= 1'b0;
      end else begin
         prio_out <= prio_ff;
         is_primary <= state_ff == ST_P_OPER || state_ff == ST_P_XCHG;
         is_secondary <= state_ff == ST_S_OPER;
      end
   end
endmodule : crf_redundancy
`default_nettype wire

// ==== verilog/crf_cfg.svh ====
// constants for the controller redundancy state machine
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
`define CRF_CLK_HZ 100000000
`define CRF_MS_PER_S 1000
`define CRF_TICK_CYCLES (`CRF_CLK_HZ / `CRF_MS_PER_S)
`define CRF_HELLO_MS_RST 16'h00c8
`define CRF_PRIO_RSVD 8'h00
`define CRF_PRIO_FORCE 8'h01
`define CRF_PRIO_PRIMARY 8'h02
`define CRF_PRIO_DEFAULT 8'h80
`define CRF_PRIO_REFUSE 8'hff
`define CRF_ADDR_CTRL 4'h0
`define CRF_ADDR_HELLO 4'h1
`define CRF_ADDR_PRIO 4'h2
`define CRF_ADDR_STATUS 4'h3
`define CRF_ADDR_PEER 4'h4
`define CRF_CTRL_EN_BIT 0
`define CRF_CTRL_HANDOVER_BIT 1
`define CRF_CTRL_ERRCLR_BIT 2
`endif

// ==== verilog/crf_pkg.sv ====
// types for the controller redundancy state machine
package crf_pkg;
   typedef enum logic [3:0] {
      ST_INIT, ST_ELECT, ST_XCHG, ST_P_INIT, ST_P_OPER, ST_P_XCHG, ST_S_INIT, ST_S_TOPO, ST_S_ALLOC,
      ST_S_NAME, ST_S_SYNC, ST_S_OPER
   } crf_state_type;
   typedef struct packed {
      logic prio_xchg;
      logic announce_primary;
      logic announce_peer;
      logic link_bringup;
      logic id_request;
      logic get_topology_msg;
      logic get_id_alloc_msg;
      logic get_name_data;
      logic sync_achieved_msg;
      logic hello;
      logic isolate_link;
   } crf_cmd_type;
   typedef struct packed {
      logic xchg_done;
      logic [7:0] prio;
      logic [63:0] name;
      logic conflict;
   } crf_xchg_type;
endpackage : crf_pkg

// ==== verification/crf_redundancy_monitor.sv ====
// assertions for the redundancy state machine
`timescale 1ns/100ps
`default_nettype none
module crf_redundancy_monitor
   import crf_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic [3:0] reg_addr, // address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write
   input wire crf_xchg_type xchg_rsp, // exchange result
   input wire logic prio_req_rx, // peer request
   input wire logic [7:0] prio_req_val, // its priority
   input wire logic id_granted, // grant
   input wire logic sync_rx, // sync message
   input wire logic primary_req_rx, // primary request
   input wire crf_cmd_type cmd, // actions
   input wire logic req_accept, // request done
   input wire logic [7:0] prio_out, // priority
   input wire logic is_primary, // primary
   input wire logic is_secondary // secondary
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic ctl_wr = reg_wr && reg_addr == 4'h0;
   // ==========
   // properties
   sequence s_grant;
      cmd.id_request ##[1:4] id_granted;
   endsequence
   sequence s_enter_p;
      cmd.announce_primary && cmd.link_bringup;
   endsequence
   property p_accept; req_accept |-> $past(primary_req_rx); endproperty
   a_accept: assert property (p_accept) else $error("accept without request");
   property p_grant; s_grant |-> ##[1:3] s_enter_p; endproperty
   a_grant: assert property (p_grant) else $error("no entry actions after grant");
   property p_prim_prio; $rose(is_primary) |-> ##[0:2] prio_out == 8'h02; endproperty
   a_prim_prio: assert property (p_prim_prio) else $error("primary priority wrong");
   property p_sync; is_primary && sync_rx |-> ##[1:3] (cmd.announce_primary && cmd.announce_peer); endproperty
   a_sync: assert property (p_sync) else $error("no role announce on sync");
   property p_roles; !(is_primary && is_secondary); endproperty
   a_roles: assert property (p_roles) else $error("both roles at once");
   property p_takeover;
      is_secondary && prio_req_rx && prio_req_val == 8'hff |-> ##[1:4] is_primary;
   endproperty
   a_takeover: assert property (p_takeover) else $error("no takeover on refuse");
   property p_handover; is_primary && ctl_wr && reg_wdata[1:0] == 2'b11 |-> ##[1:6] is_secondary; endproperty
   a_handover: assert property (p_handover) else $error("no handover");
   property p_disable; ctl_wr && !reg_wdata[0] |-> ##[1:3] !(is_primary || is_secondary); endproperty
   a_disable: assert property (p_disable) else $error("roles kept when disabled");
   property p_dual;
      xchg_rsp.xchg_done && xchg_rsp.prio == 8'h01 && prio_out == 8'h01 |=> (!is_primary && !cmd.id_request) [*4];
   endproperty
   a_dual: assert property (p_dual) else $error("election after double force");
endmodule : crf_redundancy_monitor
bind crf_redundancy crf_redundancy_monitor i_crf_redundancy_monitor (.clk_sys, .rst, .reg_addr, .reg_wdata,
   .reg_wr, .xchg_rsp, .prio_req_rx, .prio_req_val, .id_granted, .sync_rx, .primary_req_rx, .cmd, .req_accept,
   .prio_out, .is_primary, .is_secondary);
`default_nettype wire

// ==== verification/crf_peer_model.sv ====
// model of the peer controller and fabric answers
`timescale 1ns/100ps
`default_nettype none
module crf_peer_model
   import crf_pkg::*;
#(
   parameter int HELLO_CYC = 40
) (
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire crf_cmd_type cmd, // device actions
   input wire logic hello_en, // peer alive
   input wire logic slow, // late answers
   input wire logic [7:0] peer_prio, // peer priority
   input wire logic [63:0] peer_name, // peer name
   input wire logic conflict, // id conflict
   output logic hello_rx, // peer hello
   output crf_xchg_type xchg_rsp, // exchange answer
   output logic id_granted, // fabric grant
   output logic step_done // fetch answered
);
   logic [15:0] hcnt;
   logic [2:0] cd [3];
   wire logic [2:0] go = {cmd.prio_xchg, cmd.id_request, cmd.get_topology_msg | cmd.get_id_alloc_msg | cmd.get_name_data};
   wire logic [2:0] dly = slow ? 3'h4 : 3'h1;
   // ==========
   // answers
   always_ff @(posedge clk_sys or posedge rst) begin
      for (int i = 0; i < 3; i++) begin
         if (rst) cd[i] <= 3'h0;
         else if (go[2 - i]) cd[i] <= dly;
         else if (cd[i] != 3'h0) cd[i] <= cd[i] - 3'h1;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) hcnt <= 16'h0;
      else if (!hello_en || hcnt == 16'(HELLO_CYC - 1)) hcnt <= 16'h0;
      else hcnt <= hcnt + 16'h1;
   end
   assign hello_rx = hello_en && hcnt == 16'h1;
   assign id_granted = cd[1] == 3'h1;
   assign step_done = cd[2] == 3'h1;
   always_comb begin
      xchg_rsp.xchg_done = cd[0] == 3'h1;
      // released fields show the inverse, never a stale answer
      xchg_rsp.prio = xchg_rsp.xchg_done ? peer_prio : ~peer_prio;
      xchg_rsp.name = xchg_rsp.xchg_done ? peer_name : ~peer_name;
      xchg_rsp.conflict = xchg_rsp.xchg_done ? conflict : ~conflict;
   end
endmodule : crf_peer_model
`default_nettype wire

// ==== verification/crf_redundancy_tb.sv ====
// self-checking bench for the redundancy state machine
`timescale 1ns/100ps
`default_nettype none
module crf_redundancy_tb;
   import crf_pkg::*;
   localparam int TICK = 10;
   localparam int HP = 4;
   localparam logic [63:0] NAME = 64'h5555000000000000; // arbitrary
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sets_configured = 1'b0;
   logic fabric_ready = 1'b0;
   logic link_set_up = 1'b0;
   logic peer_fwd_reach = 1'b0;
   logic prio_req_rx = 1'b0;
   logic [7:0] prio_req_val = 8'h0;
   logic sync_rx = 1'b0;
   logic primary_req_rx = 1'b0;
   logic hello_en = 1'b0;
   logic slow = 1'b0;
   logic conflict = 1'b0;
   logic [7:0] peer_prio = 8'h80;
   logic [63:0] peer_name = 64'h0;
   logic [31:0] reg_rdata;
   logic hello_rx, id_granted, step_done, req_accept, is_primary, is_secondary;
   logic [7:0] prio_out;
   crf_xchg_type xchg_rsp;
   crf_cmd_type cmd;
   crf_cmd_type seen;
   logic clr = 1'b0;
   logic [15:0] order;
   logic [3:0] hellos;
   logic [31:0] rv;
   logic [7:0] lp;
   logic ex;
   int seed = 32'h56b94de2;
   int miscompares = 0;
   int checks_done = 0;
   crf_redundancy #(.TICK_CYCLES(TICK), .LOCAL_NAME(NAME)) i_crf_redundancy (.clk_sys, .rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sets_configured, .fabric_ready, .link_set_up, .peer_fwd_reach,
      .hello_rx, .xchg_rsp, .prio_req_rx, .prio_req_val, .id_granted, .step_done, .sync_rx, .primary_req_rx,
      .cmd, .req_accept, .prio_out, .is_primary, .is_secondary);
   crf_peer_model #(.HELLO_CYC(HP * TICK)) i_crf_peer_model (.clk_sys, .rst, .cmd, .hello_en, .slow,
      .peer_prio, .peer_name, .conflict, .hello_rx, .xchg_rsp, .id_granted, .step_done);
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      seen <= clr ? '0 : seen | cmd;
      hellos <= clr ? 4'h0 : hellos + {3'h0, cmd.hello};
      if (clr) order <= 16'h0;
      else if (cmd.get_topology_msg || cmd.get_id_alloc_msg || cmd.get_name_data || cmd.sync_achieved_msg)
         order <= {order[11:0], cmd.get_topology_msg, cmd.get_id_alloc_msg, cmd.get_name_data, cmd.sync_achieved_msg};
   end
   // ==========
   // tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      rv = reg_rdata;
   endtask : rd
   task automatic clear;
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
   endtask : clear
   task automatic wait_role(input logic p, input logic s);
      for (int i = 0; i < 3000 && !(is_primary === p && is_secondary === s); i++)
         @(posedge clk_sys);
      chk("role", {30'h0, p, s}, {30'h0, is_primary, is_secondary});
   endtask : wait_role
   function automatic logic wins(input logic [7:0] a, input logic [7:0] b, input logic [63:0] n);
      return a < b || (a == b && NAME < n);
   endfunction : wins
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #800000;
      miscompares++;
      wrap_up();
   end
   // ==========
   // scenarios
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(4'h1);
      chk("hello", 32'h00c8, rv);
      wr(4'h2, 32'h0);
      rd(4'h2);
      chk("prio", 32'h80, rv);
      wr(4'h1, 32'h0);
      wr(4'h1, HP);
      rd(4'h1);
      chk("hello set", HP, rv);
      rd(4'hf);
      chk("unmapped", 32'h0, rv);
      wr(4'h0, 32'h1);
      repeat (20) @(posedge clk_sys);
      rd(4'h3);
      chk("state", {28'h0, ST_INIT}, {28'h0, rv[3:0]});
      sets_configured <= 1'b1;
      fabric_ready <= 1'b1;
      clear();
      wait_role(1'b1, 1'b0);
      chk("prio out", 32'h02, {24'h0, prio_out});
      chk("entry", 32'h7, {29'h0, seen.prio_xchg, seen.announce_primary, seen.link_bringup});
      @(posedge clk_sys);
      sync_rx <= 1'b1;
      peer_fwd_reach <= 1'b1;
      hello_en <= 1'b1;
      @(posedge clk_sys);
      sync_rx <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("peer announce", 32'h1, {31'h0, seen.announce_peer});
      clear();
      repeat (3 * HP * TICK + 1) @(posedge clk_sys);
      chk("hellos", 32'h3, {28'h0, hellos});
      for (int i = 0; i < 100 && hello_rx !== 1'b1; i++)
         @(posedge clk_sys);
      chk("peer hello", 32'h1, {31'h0, hello_rx});
      hello_en <= 1'b0;
      clear();
      repeat (80) @(posedge clk_sys);
      chk("early down", 32'h0, {31'h0, seen.announce_primary});
      repeat (30) @(posedge clk_sys);
      chk("down announce", 32'h1, {31'h0, seen.announce_primary});
      rd(4'h3);
      chk("expired", 32'h1, {31'h0, rv[6]});
      conflict <= 1'b1;
      link_set_up <= 1'b1;
      hello_en <= 1'b1;
      clear();
      repeat (20) @(posedge clk_sys);
      chk("isolate", 32'h3, {30'h0, seen.isolate_link, is_primary});
      link_set_up <= 1'b0;
      conflict <= 1'b0;
      peer_prio <= 8'h01;
      repeat (5) @(posedge clk_sys);
      link_set_up <= 1'b1;
      wait_role(1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk("restored", 32'h80, {24'h0, prio_out});
      rd(4'h4);
      chk("peer prio", 32'h01, rv);
      link_set_up <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rd(4'h3);
      chk("back", {28'h0, ST_S_INIT}, {28'h0, rv[3:0]});
      clear();
      link_set_up <= 1'b1;
      primary_req_rx <= 1'b1;
      @(posedge clk_sys);
      primary_req_rx <= 1'b0;
      #1;
      chk("accept", 32'h1, {31'h0, req_accept});
      repeat (40) @(posedge clk_sys);
      chk("fetch order", 32'h8421, {16'h0, order});
      rd(4'h3);
      chk("synced", {28'h0, ST_S_OPER}, {28'h0, rv[3:0]});
      @(posedge clk_sys);
      prio_req_val <= 8'hff;
      prio_req_rx <= 1'b1;
      @(posedge clk_sys);
      prio_req_rx <= 1'b0;
      wait_role(1'b1, 1'b0);
      wr(4'h0, 32'h3);
      wait_role(1'b0, 1'b1);
      hello_en <= 1'b0;
      wait_role(1'b1, 1'b0);
      wr(4'h0, 32'h0);
      wait_role(1'b0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         rv = $random(seed);
         lp = 8'h03 + rv[7:0] % 8'hfc;
         slow <= rv[8];
         peer_prio <= (i == 0) ? lp : 8'h03 + rv[23:16] % 8'hfc;
         peer_name <= {$random(seed), $random(seed)};
         hello_en <= 1'b1;
         wr(4'h2, {24'h0, lp});
         ex = wins(lp, peer_prio, peer_name);
         wr(4'h0, 32'h1);
         wait_role(ex, !ex);
         wr(4'h0, 32'h0);
         wait_role(1'b0, 1'b0);
      end
      peer_prio <= 8'h01;
      wr(4'h2, 32'h1);
      wr(4'h0, 32'h1);
      repeat (30) @(posedge clk_sys);
      rd(4'h3);
      chk("error", 32'h1, {31'h0, rv[5]});
      rd(4'h0);
      chk("enable", 32'h0, {31'h0, rv[0]});
      wr(4'h0, 32'h4);
      rd(4'h3);
      chk("error clear", 32'h0, {31'h0, rv[5]});
      wrap_up();
   end
endmodule : crf_redundancy_tb
`default_nettype wire
